//--- verilog/pd_mac_reset_irq_ctl.sv
// Purpose: Reset control and start-of-packet interrupt enables of the protocol MAC
// Assumes: APB slave, zero wait states, registers in byte lane 0
// Notes:   Reset outputs are active low, the clears and enables active high; all fan out to the rest of the MAC
`timescale 1ns/1ps
module pd_mac_reset_irq_ctl
    import pd_rst_pkg::*;
(
    input  wire logic              sys_clk,            // System clock, 25 MHz
    input  wire logic              resetn,             // External reset, active low
    // APB slave
    input  wire logic              psel,               // Slave select
    input  wire logic              penable,            // Access phase
    input  wire logic              pwrite,             // Write direction
    input  wire logic [ADDR_W-1:0] paddr,              // Byte address
    input  wire logic [DATA_W-1:0] pwdata,             // Write data
    input  wire logic [3:0]        pstrb,              // Byte strobes
    output logic      [DATA_W-1:0] prdata,             // Read data
    output logic                   pready,             // Always ready
    output logic                   pslverr,            // Unmapped address
    // Events from the receive path
    input  wire logic [SOP_W-1:0]  sop_detect,         // Ordered-set kind pulses
    output logic                   sop_irq,            // Interrupt level
    // Reset fan-out; the clears and enables are active high, the rest active low
    output logic                   mac_rst_n,          // Whole MAC
    output logic                   mac_cfg_rst_n,      // MAC config incl. codec timing
    output logic                   codec_rst_n,        // Encoder and decoder logic
    output logic                   receive_controller_fsm_rst_n,       // Receive controller FSM
    output logic                   transmit_controller_fsm_rst_n,       // Transmit controller FSM
    output logic                   tx_serdes_rst_n,    // Serialiser and 4b5b encoder
    output logic                   tx_cmd_clr,         // Clear go and reset-send bits
    output logic                   fw_tx_en_clr,       // Clear firmware transmit enable
    output logic                   keep_state_rst_n,   // Counters, FIFO, CDR, CRC, BIST, PM
    output logic                   hard_reset_det_en,  // Hard and cable reset detect
    output logic                   receiver_enable     // Receiver enable level
);
    logic             rst_n;
    logic [4:0]       sop_en_q;
    logic             mac_srst_q;
    logic             codec_srst_q;
    logic             proto_rst_q;
    logic             rx_en_q;
    logic [DATA_W-1:0] prdata_q;
    logic             pslverr_q;
    logic [SOP_W-1:0] sop_status;

    // Word index decode, used for both reads and writes
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [IDX_W-1:0] idx);
        hit = (a[ADDR_W-1:2] == idx);
    endfunction : hit

    // External reset released through two flip-flops
    rst_release_sync u_rst_sync (
        .clk    (sys_clk),
        .arst_n (resetn),
        .srst_n (rst_n)
    );

    // APB phase decode
    wire setup_ph  = psel & ~penable;
    wire access_ph = psel & penable;
    wire wr_lane0  = access_ph & pwrite & pstrb[0];

    // Register selection
    wire sel_sop_en   = hit(paddr, IDX_SOP_EN);
    wire sel_rst_ctl  = hit(paddr, IDX_RST_CTL);
    wire sel_sop_stat = hit(paddr, IDX_SOP_STAT);
    wire sel_sop_clr  = hit(paddr, IDX_SOP_CLR);
    wire sel_rx_cfg   = hit(paddr, IDX_RX_CFG);
    wire sel_any      = sel_sop_en | sel_rst_ctl | sel_sop_stat
                      | sel_sop_clr | sel_rx_cfg;

    // Write strobes
    wire wr_sop_en  = wr_lane0 & sel_sop_en;
    wire wr_rst_ctl = wr_lane0 & sel_rst_ctl;
    wire wr_sop_clr = wr_lane0 & sel_sop_clr;
    wire wr_rx_cfg  = wr_lane0 & sel_rx_cfg;

    // Start-of-packet interrupt enables; cleared at reset and by soft reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sop_en_q <= SOP_EN_RST;
        end else if (mac_srst_q) begin
            sop_en_q <= SOP_EN_RST;
        end else if (wr_sop_en) begin
            sop_en_q <= pwdata[SOP_W-1:0];
        end
    end

    // Soft reset bit: cleared by the external reset or a write of zero, never by itself
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mac_srst_q <= CTL_BIT_RST;
        end else if (wr_rst_ctl) begin
            mac_srst_q <= pwdata[BIT_MAC_SRST];
        end
    end

    // Codec and protocol reset bits; the MAC soft reset clears them
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            codec_srst_q <= CTL_BIT_RST;
            proto_rst_q  <= CTL_BIT_RST;
        end else if (mac_srst_q) begin
            codec_srst_q <= CTL_BIT_RST;
            proto_rst_q  <= CTL_BIT_RST;
        end else if (wr_rst_ctl) begin
            codec_srst_q <= pwdata[BIT_CODEC_SRST];
            proto_rst_q  <= pwdata[BIT_PROTO_RST];
        end
    end

    // Receiver enable: survives protocol and codec resets
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_en_q <= RX_EN_RST;
        end else if (mac_srst_q) begin
            rx_en_q <= RX_EN_RST;
        end else if (wr_rx_cfg) begin
            rx_en_q <= pwdata[BIT_RX_EN];
        end
    end

    // Sticky status, clear register and interrupt gating
    sop_irq_status u_sop_irq (
        .clk       (sys_clk),
        .rst_n     (rst_n),
        .soft_clr  (mac_srst_q),
        .sop_event (sop_detect),
        .clr_wr    (wr_sop_clr),
        .clr_mask  (pwdata[SOP_W-1:0]),
        .enables   (sop_en_q),
        .status    (sop_status),
        .irq       (sop_irq)
    );

    // Read data selection; reserved bits and write-only clear read zero
    wire [7:0] rd_sop_en  = {3'h0, sop_en_q};
    wire [7:0] rd_rst_ctl = {mac_srst_q, codec_srst_q, 5'h00, proto_rst_q};
    wire [7:0] rd_stat    = {3'h0, sop_status};
    wire [7:0] rd_rx_cfg  = {7'h00, rx_en_q};
    wire [7:0] rd_byte    = sel_sop_en   ? rd_sop_en
                          : sel_rst_ctl  ? rd_rst_ctl
                          : sel_sop_stat ? rd_stat
                          : sel_rx_cfg   ? rd_rx_cfg
                          : 8'h00;

    // Read data and error captured in the setup cycle, held through access
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (setup_ph) begin
            prdata_q  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            pslverr_q <= ~sel_any;
        end
    end

    assign prdata  = prdata_q;
    assign pslverr = pslverr_q & access_ph;
    assign pready  = 1'b1;

    // Whole MAC held while the soft reset bit reads one
    assign mac_rst_n     = rst_n & ~mac_srst_q;
    // Configuration kept by the codec reset, cleared by the MAC reset
    assign mac_cfg_rst_n = rst_n & ~mac_srst_q;
    // Codec logic only; its timing registers sit under mac_cfg_rst_n
    assign codec_rst_n   = rst_n & ~mac_srst_q & ~codec_srst_q;

    // Protocol reset targets
    assign receive_controller_fsm_rst_n    = mac_rst_n & ~proto_rst_q;
    assign transmit_controller_fsm_rst_n    = mac_rst_n & ~proto_rst_q;
    assign tx_serdes_rst_n = mac_rst_n & ~proto_rst_q;
    assign tx_cmd_clr      = proto_rst_q;
    assign fw_tx_en_clr    = proto_rst_q;

    // Logic the protocol reset must leave alone
    assign keep_state_rst_n = mac_rst_n;

    // Detection stays armed across a protocol reset
    assign hard_reset_det_en = rx_en_q;
    assign receiver_enable   = rx_en_q;
endmodule : pd_mac_reset_irq_ctl

//--- common/pd_rst_pkg.sv
// Purpose: Shared constants for the MAC reset and start-of-packet interrupt control block
// Assumes: APB register access, 32-bit data, one aligned word per register
// Notes:   Register indices are word indices; byte address is four times the index
package pd_rst_pkg;
    localparam int          DATA_W        = 32;
    localparam int          ADDR_W        = 16;
    localparam int          IDX_W         = 14;
    localparam int          SOP_W         = 5;
    localparam int          REG_W         = 8;
    // Register indices (byte address = index * 4)
    localparam logic [13:0] IDX_SOP_EN    = 14'h1a8a;
    localparam logic [13:0] IDX_RST_CTL   = 14'h1a8b;
    localparam logic [13:0] IDX_SOP_STAT  = 14'h1a8c;
    localparam logic [13:0] IDX_SOP_CLR   = 14'h1a8d;
    localparam logic [13:0] IDX_RX_CFG    = 14'h1a8e;
    // Field positions in the reset control register
    localparam int          BIT_MAC_SRST  = 7;
    localparam int          BIT_CODEC_SRST = 6;
    localparam int          BIT_PROTO_RST = 0;
    // Field position of the receiver enable in the receive config register
    localparam int          BIT_RX_EN     = 0;
    // Values after reset
    localparam logic [4:0]  SOP_EN_RST    = 5'h00;
    localparam logic [4:0]  SOP_STAT_RST  = 5'h00;
    localparam logic        CTL_BIT_RST   = 1'b0;
    localparam logic        RX_EN_RST     = 1'b0;
endpackage : pd_rst_pkg

//--- verilog/rst_release_sync.sv
// Purpose: Asynchronous assert, synchronous release of the external reset
// Assumes: Active-low reset input
// Notes:   Two flip-flops; only the second one is used downstream
`timescale 1ns/1ps
module rst_release_sync (
    input  wire logic clk,      // System clock
    input  wire logic arst_n,   // Raw active-low reset
    output logic      srst_n    // Released reset copy
);
    logic meta_q;
    logic hold_q;

    // Two-stage release chain
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= 1'b0;
            hold_q <= 1'b0;
        end else begin
            meta_q <= 1'b1;
            hold_q <= meta_q;
        end
    end

    assign srst_n = hold_q;
endmodule : rst_release_sync

//--- verilog/sop_irq_status.sv
// Purpose: Sticky start-of-packet status bits and gated interrupt output
// Assumes: Event inputs are one-cycle pulses synchronous to clk
// Notes:   Set wins over a clear in the same cycle
`timescale 1ns/1ps
module sop_irq_status
    import pd_rst_pkg::*;
(
    input  wire logic             clk,        // System clock
    input  wire logic             rst_n,      // Synchronised reset
    input  wire logic             soft_clr,   // MAC soft reset hold
    input  wire logic [SOP_W-1:0] sop_event,  // Detected ordered-set pulses
    input  wire logic             clr_wr,     // Clear register write strobe
    input  wire logic [SOP_W-1:0] clr_mask,   // Bits to clear
    input  wire logic [SOP_W-1:0] enables,    // Interrupt enables
    output logic      [SOP_W-1:0] status,     // Sticky status
    output logic                  irq         // Level interrupt
);
    logic [SOP_W-1:0] stat_q;
    logic [SOP_W-1:0] stat_d;
    logic [SOP_W-1:0] clr_eff;

    // Clear only on a write; events set whatever the enables, except while soft_clr holds
    assign clr_eff = clr_wr ? clr_mask : '0;
    assign stat_d  = (stat_q & ~clr_eff) | sop_event;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_q <= SOP_STAT_RST;
        end else if (soft_clr) begin
            stat_q <= SOP_STAT_RST;
        end else begin
            stat_q <= stat_d;
        end
    end

    // Each enable bit gates its own kind only
    assign status = stat_q;
    assign irq    = |(stat_q & enables);
endmodule : sop_irq_status

//--- tb/pd_mac_reset_irq_ctl_props.sv
// Purpose: Port checks of the reset and interrupt control block
// Assumes: One clock, external reset active low
// Notes:   Bound from the testbench top
`timescale 1ns/1ps
module pd_mac_reset_irq_ctl_props (
    input wire logic sys_clk,           // Clock
    input wire logic resetn,            // Reset
    input wire logic sop_irq,           // Interrupt
    input wire logic mac_rst_n,         // MAC reset
    input wire logic mac_cfg_rst_n,     // Config reset
    input wire logic codec_rst_n,       // Codec reset
    input wire logic receive_controller_fsm_rst_n,      // Rx FSM reset
    input wire logic transmit_controller_fsm_rst_n,      // Tx FSM reset
    input wire logic tx_serdes_rst_n,   // Serialiser reset
    input wire logic tx_cmd_clr,        // Command clear
    input wire logic fw_tx_en_clr,      // Fw transmit clear
    input wire logic keep_state_rst_n,  // Kept state reset
    input wire logic hard_reset_det_en, // Detect enable
    input wire logic receiver_enable    // Receiver enable
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // Reset fan-out relations
    AST_CFG_KEEP: assert property (mac_cfg_rst_n == mac_rst_n && keep_state_rst_n == mac_rst_n)
        else $error("config or kept state reset moved alone");
    AST_CODEC_MAC: assert property (!mac_rst_n |-> !codec_rst_n)
        else $error("codec out of reset during MAC reset");
    AST_PROTO_HOLD: assert property (tx_cmd_clr |-> !receive_controller_fsm_rst_n && !transmit_controller_fsm_rst_n && !tx_serdes_rst_n)
        else $error("controller free during protocol reset");
    AST_CLR_PAIR: assert property (tx_cmd_clr == fw_tx_en_clr)
        else $error("command clears differ");
    AST_DET_STAY: assert property (tx_cmd_clr && mac_rst_n && $past(mac_rst_n)
        |-> $stable(hard_reset_det_en) && hard_reset_det_en == receiver_enable)
        else $error("detection changed by protocol reset");
    AST_PROTO_FREE: assert property ($fell(tx_cmd_clr) && mac_rst_n |-> receive_controller_fsm_rst_n && transmit_controller_fsm_rst_n)
        else $error("controllers not released");
    AST_SOFT_HOLD: assert property ($fell(mac_rst_n) |=> !mac_rst_n ##1 !mac_rst_n)
        else $error("soft reset ended by itself");
    AST_IRQ_SOFT: assert property (!mac_rst_n && $past(mac_rst_n) == 1'b0 |-> !sop_irq)
        else $error("interrupt during MAC reset");
endmodule : pd_mac_reset_irq_ctl_props

//--- tb/tb_top.sv
// Purpose: Self-checking bench of the reset and interrupt control block
// Assumes: APB master driving on rising edges
// Notes:   Reads are noted in a queue and checked by a monitor
`timescale 1ns/1ps
module tb_top;
    import pd_rst_pkg::*;
    logic              sys_clk, resetn, psel, penable, pwrite, pready, pslverr, sop_irq;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata;
    logic [3:0]        pstrb;
    logic [SOP_W-1:0]  sop_detect, ev;
    logic              mac_rst_n, mac_cfg_rst_n, codec_rst_n, receive_controller_fsm_rst_n, transmit_controller_fsm_rst_n;
    logic              tx_serdes_rst_n, tx_cmd_clr, fw_tx_en_clr, keep_state_rst_n;
    logic              hard_reset_det_en, receiver_enable;
    logic [32:0]       expq[$];
    int                error_cnt, cmp_count;
    wire  [10:0]       rsts = {mac_rst_n, mac_cfg_rst_n, codec_rst_n, receive_controller_fsm_rst_n,
        transmit_controller_fsm_rst_n, tx_serdes_rst_n, tx_cmd_clr, fw_tx_en_clr, keep_state_rst_n,
        hard_reset_det_en, receiver_enable};
    pd_mac_reset_irq_ctl pd_mac_reset_irq_ctl_inst (.sys_clk, .resetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .sop_detect, .sop_irq,
        .mac_rst_n, .mac_cfg_rst_n, .codec_rst_n, .receive_controller_fsm_rst_n, .transmit_controller_fsm_rst_n,
        .tx_serdes_rst_n, .tx_cmd_clr, .fw_tx_en_clr, .keep_state_rst_n,
        .hard_reset_det_en, .receiver_enable);
    // Clock
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    task cmp(input string nm, input logic [32:0] e, input logic [32:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    task chk(input logic [10:0] e);
        @(negedge sys_clk);
        cmp("resets", 33'(e), 33'(rsts));
    endtask : chk
    // One APB transfer; a read notes its expected {pslverr, prdata}
    task apb(input logic wr, input logic [13:0] idx, input logic [7:0] d, input logic [32:0] e);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        if (!wr) expq.push_back(e);
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge sys_clk);
        end
        if (n >= 50) begin
            error_cnt++;
            test_done;
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task test_done;
        $display("errors %0d comparisons %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    // Read monitor takes the oldest note at each completed read
    always @(posedge sys_clk) begin
        if (psel && penable && !pwrite && pready === 1'b1)
            cmp("read", expq.pop_front(), {pslverr, prdata});
    end
    // Watchdog
    initial begin
        #100000;
        error_cnt++;
        test_done;
    end
    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata, sop_detect} = '0;
        pstrb = 4'h1;
        resetn = 1'b0;
        error_cnt = 0;
        cmp_count = 0;
        void'($urandom(56819));
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        apb(1'b0, IDX_SOP_EN, 8'h0, {28'h0, SOP_EN_RST});
        apb(1'b0, IDX_RST_CTL, 8'h0, 33'h0);
        apb(1'b0, 14'h0, 8'h0, {1'b1, 32'h0});
        pstrb <= 4'h0;
        apb(1'b1, IDX_SOP_EN, 8'h1f, 33'h0);
        pstrb <= 4'h1;
        apb(1'b0, IDX_SOP_EN, 8'h0, 33'h0);
        for (int k = 0; k < SOP_W; k++) begin
            apb(1'b1, IDX_SOP_EN, 8'(1 << k), 33'h0);
            ev = SOP_W'($urandom);
            ev[k] = k[0];
            @(posedge sys_clk);
            sop_detect <= ev;
            @(posedge sys_clk);
            sop_detect <= '0;
            @(negedge sys_clk);
            cmp("irq", 33'(ev[k]), 33'(sop_irq));
            apb(1'b0, IDX_SOP_STAT, 8'h0, {28'h0, ev});
            apb(1'b1, IDX_SOP_CLR, 8'h1f, 33'h0);
        end
        // Status index ignores writes; clear index reads zero
        apb(1'b1, IDX_SOP_STAT, 8'h1f, 33'h0);
        apb(1'b0, IDX_SOP_STAT, 8'h0, 33'h0);
        apb(1'b0, IDX_SOP_CLR, 8'h0, 33'h0);
        apb(1'b1, IDX_RX_CFG, 8'h01, 33'h0);
        apb(1'b1, IDX_RST_CTL, 8'h01, 33'h0);
        chk(11'b11100011111);
        apb(1'b0, IDX_RX_CFG, 8'h0, 33'h1);
        apb(1'b0, IDX_SOP_EN, 8'h0, 33'h10);
        apb(1'b1, IDX_RST_CTL, 8'h00, 33'h0);
        chk(11'b11111100111);
        apb(1'b1, IDX_RST_CTL, 8'h40, 33'h0);
        chk(11'b11011100111);
        apb(1'b1, IDX_RST_CTL, 8'h80, 33'h0);
        @(posedge sys_clk);
        chk(11'b00000000000);
        apb(1'b0, IDX_RST_CTL, 8'h0, 33'h80);
        apb(1'b0, IDX_SOP_EN, 8'h0, 33'h0);
        apb(1'b1, IDX_RST_CTL, 8'h00, 33'h0);
        chk(11'b11111100100);
        // External reset in mid-run clears a set soft reset bit
        apb(1'b1, IDX_RST_CTL, 8'h80, 33'h0);
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        apb(1'b0, IDX_RST_CTL, 8'h0, 33'h0);
        chk(11'b11111100100);
        test_done;
    end
endmodule : tb_top
bind pd_mac_reset_irq_ctl pd_mac_reset_irq_ctl_props pd_mac_reset_irq_ctl_props_inst (
    .sys_clk, .resetn, .sop_irq, .mac_rst_n, .mac_cfg_rst_n, .codec_rst_n, .receive_controller_fsm_rst_n,
    .transmit_controller_fsm_rst_n, .tx_serdes_rst_n, .tx_cmd_clr, .fw_tx_en_clr, .keep_state_rst_n,
    .hard_reset_det_en, .receiver_enable);
